// ===== verilog/bpf_pkg.sv
/*
 * Shared constants of the buffered parallel FIFO port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bpf_pkg;
  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int AF_WORDS = 127;
  localparam int OSC_DIV_W = 16;
  localparam int PA_W = 8;
  localparam int PB_W = 4;
  localparam int PC_W = 3;
  localparam int PD_W = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int ACK_DELAY = 2;
  localparam int OSC_MIN_HZ = 1000;
  localparam int OSC_MAX_HZ = 40000000;
  localparam int MAX_WORDS_PER_S = 8000000;
  localparam int MAX_BYTES_PER_S = 16000000;
  localparam logic [OSC_DIV_W-1:0] OSC_DIV_RST = 16'h0003;
endpackage : bpf_pkg

// ===== verilog/bpf_port.sv
/*
 * Buffered 16-bit parallel port: dual-clock FIFOs, word strobe logic
 * on the link clock, and four side ports on the host clock.
 * Assumes link_clk_i runs free and that host-side config is static
 * while words are moving.
 */
// Functional notes
// - Receive acknowledge pulses a fixed delay after each word written.
// - Transmit pops a word per strobe rise while go is low and data waits.
// - Word strobe comes from the external pin or the internal oscillator.
// - Internal oscillator period is programmable by a divider.
// - All sixteen data lines switch direction together.
// - Four side ports A to D; A and B have their own direction controls, C and D share one.
// - Side ports are eight, four, three and three bits wide.
// - Ports C and D always take opposite directions.
// - Path sustains eight million sixteen-bit words per second.
// - Receive writes only while go is low and FIFO not full.
// - Almost-full flag rises within 127 words of full, in receive mode only.
// - Empty flag follows the acknowledge and blocks further pops.
// - With transmit go high the bus word holds and no ack appears.
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Dual-clock FIFO
// ****************************************
module bpf_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic wclk_i,
  input wire logic wrst_n_i,
  input wire logic wr_valid_i,
  input wire logic [W-1:0] wr_data_i,
  output logic wr_ready_o,
  output logic [$clog2(DEPTH):0] wr_level_o,
  input wire logic rclk_i,
  input wire logic rrst_n_i,
  output logic rd_valid_o,
  output logic [W-1:0] rd_data_o,
  input wire logic rd_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] rg1_q, rg2_q, wg1_q, wg2_q;
  logic [AW:0] wbin_d, wgray_d, rbin_d, rgray_d;
  logic push, pop;

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b = g;
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : g2b

  assign push = wr_valid_i & wr_ready_o;
  assign pop = rd_valid_o & rd_ready_i;
  assign wbin_d = wbin_q + (AW+1)'(push);
  assign wgray_d = wbin_d ^ (wbin_d >> 1);
  assign rbin_d = rbin_q + (AW+1)'(pop);
  assign rgray_d = rbin_d ^ (rbin_d >> 1);
  assign rd_data_o = mem[rbin_q[AW-1:0]];

  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= wr_data_i;
    end
  end

  // Gray pointers cross; full and level are registered for clean ports
  always_ff @(posedge wclk_i) begin
    if (!wrst_n_i) begin
      wbin_q <= '0;
      wgray_q <= '0;
      rg1_q <= '0;
      rg2_q <= '0;
      wr_ready_o <= 1'b0;
      wr_level_o <= '0;
    end else begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      rg1_q <= rgray_q;
      rg2_q <= rg1_q;
      wr_ready_o <= wgray_d != {~rg2_q[AW:AW-1], rg2_q[AW-2:0]};
      wr_level_o <= wbin_d - g2b(rg2_q);
    end
  end

  always_ff @(posedge rclk_i) begin
    if (!rrst_n_i) begin
      rbin_q <= '0;
      rgray_q <= '0;
      wg1_q <= '0;
      wg2_q <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
      wg1_q <= wgray_q;
      wg2_q <= wg1_q;
      rd_valid_o <= rgray_d != wg2_q;
    end
  end
endmodule : bpf_fifo

// ****************************************
// Port top
// ****************************************
module bpf_port #(
  parameter int DEPTH = bpf_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic tx_mode_i,
  input wire logic strobe_sel_i,
  input wire logic [bpf_pkg::OSC_DIV_W-1:0] osc_div_i,
  input wire logic host_wr_valid_i,
  input wire logic [bpf_pkg::DATA_W-1:0] host_wr_data_i,
  output logic host_wr_ready_o,
  output logic host_rd_valid_o,
  output logic [bpf_pkg::DATA_W-1:0] host_rd_data_o,
  input wire logic host_rd_ready_i,
  input wire logic [bpf_pkg::DATA_W-1:0] data_i,
  output logic [bpf_pkg::DATA_W-1:0] data_o,
  output logic [bpf_pkg::DATA_W-1:0] data_oe_o,
  input wire logic strobe_pin_i,
  input wire logic rx_go_n_i,
  input wire logic tx_go_n_i,
  output logic rx_ack_o,
  output logic tx_ack_o,
  output logic rx_almost_full_flag_o,
  output logic tx_fifo_empty_flag_o,
  input wire logic side_a_dir_i,
  input wire logic side_b_dir_i,
  input wire logic side_cd_dir_i,
  input wire logic [bpf_pkg::PA_W-1:0] side_a_out_i,
  input wire logic [bpf_pkg::PB_W-1:0] side_b_out_i,
  input wire logic [bpf_pkg::PC_W-1:0] side_c_out_i,
  input wire logic [bpf_pkg::PD_W-1:0] side_d_out_i,
  input wire logic [bpf_pkg::PA_W-1:0] side_port_a_i,
  input wire logic [bpf_pkg::PB_W-1:0] side_port_b_i,
  input wire logic [bpf_pkg::PC_W-1:0] side_port_c_i,
  input wire logic [bpf_pkg::PD_W-1:0] side_port_d_i,
  output logic [bpf_pkg::PA_W-1:0] side_port_a_o,
  output logic [bpf_pkg::PB_W-1:0] side_port_b_o,
  output logic [bpf_pkg::PC_W-1:0] side_port_c_o,
  output logic [bpf_pkg::PD_W-1:0] side_port_d_o,
  output logic [bpf_pkg::PA_W-1:0] side_port_a_oe_o,
  output logic [bpf_pkg::PB_W-1:0] side_port_b_oe_o,
  output logic [bpf_pkg::PC_W-1:0] side_port_c_oe_o,
  output logic [bpf_pkg::PD_W-1:0] side_port_d_oe_o,
  output logic [bpf_pkg::PA_W-1:0] side_a_in_o,
  output logic [bpf_pkg::PB_W-1:0] side_b_in_o,
  output logic [bpf_pkg::PC_W-1:0] side_c_in_o,
  output logic [bpf_pkg::PD_W-1:0] side_d_in_o
);
  localparam int DW = bpf_pkg::DATA_W;
  localparam int LW = $clog2(DEPTH) + 1;
  localparam int ACKD = bpf_pkg::ACK_DELAY;
  localparam int SIDE_W = bpf_pkg::PA_W + bpf_pkg::PB_W + bpf_pkg::PC_W
                          + bpf_pkg::PD_W;
  localparam logic [LW+7:0] AF_FREE = (LW+8)'(bpf_pkg::AF_WORDS);

  // ****************************************
  // Link reset and config crossings
  // ****************************************
  logic [1:0] lrst_q, mode_s_q, sel_s_q;
  logic lrst_n, tx_mode_s, sel_s;
  logic [bpf_pkg::OSC_DIV_W-1:0] div_hold_q, div_l_q;
  logic div_tgl_q;
  logic [2:0] div_tgl_s_q;
  assign lrst_n = lrst_q[1];
  assign tx_mode_s = mode_s_q[1];
  assign sel_s = sel_s_q[1];

  always_ff @(posedge link_clk_i) begin
    lrst_q <= {lrst_q[0], rst_n_i};
    mode_s_q <= {mode_s_q[0], tx_mode_i};
    sel_s_q <= {sel_s_q[0], strobe_sel_i};
  end

  // Divider word crosses by toggle; held value is stable when sampled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_hold_q <= bpf_pkg::OSC_DIV_RST;
      div_tgl_q <= 1'b0;
    end else if (osc_div_i != div_hold_q) begin
      div_hold_q <= osc_div_i;
      div_tgl_q <= ~div_tgl_q;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      div_tgl_s_q <= '0;
      div_l_q <= bpf_pkg::OSC_DIV_RST;
    end else begin
      div_tgl_s_q <= {div_tgl_s_q[1:0], div_tgl_q};
      if (div_tgl_s_q[2] != div_tgl_s_q[1]) begin
        div_l_q <= div_hold_q;
      end
    end
  end

  // ****************************************
  // Word strobe source
  // ****************************************
  logic [2:0] pin_s_q;
  logic [1:0] rxgo_s_q, txgo_s_q;
  logic [DW-1:0] din1_q, din2_q;
  logic [bpf_pkg::OSC_DIV_W-1:0] osc_cnt_q;
  logic osc_tick_q, strobe_rise, ext_rise;

  always_ff @(posedge link_clk_i) begin
    pin_s_q <= {pin_s_q[1:0], strobe_pin_i};
    rxgo_s_q <= {rxgo_s_q[0], rx_go_n_i};
    txgo_s_q <= {txgo_s_q[0], tx_go_n_i};
    din1_q <= data_i;
    din2_q <= din1_q;
  end

  // Tick rate is link rate over divider plus one
  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      osc_cnt_q <= '0;
      osc_tick_q <= 1'b0;
    end else if (osc_cnt_q >= div_l_q) begin
      osc_cnt_q <= '0;
      osc_tick_q <= 1'b1;
    end else begin
      osc_cnt_q <= osc_cnt_q + 1'b1;
      osc_tick_q <= 1'b0;
    end
  end

  assign ext_rise = pin_s_q[1] & ~pin_s_q[2];
  assign strobe_rise = sel_s ? osc_tick_q : ext_rise;

  chk_osc_tick_single: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) osc_tick_q |=> !osc_tick_q)
    else $error("oscillator tick longer than one cycle");
  chk_strobe_source: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) (!sel_s && strobe_rise) |-> $past(pin_s_q[1])
      == 1'b0)
    else $error("external strobe without rising pin edge");

  // ****************************************
  // FIFOs, one per direction
  // ****************************************
  logic rx_push, rx_wr_ready, tx_pop, tx_rd_valid;
  logic [LW-1:0] rx_level;
  logic [DW-1:0] tx_rd_data;

  // Separate FIFOs keep each direction's pointers in one pair of domains
  bpf_fifo #(.W(DW), .DEPTH(DEPTH)) u_rx_fifo (
    .wclk_i(link_clk_i),
    .wrst_n_i(lrst_n),
    .wr_valid_i(rx_push),
    .wr_data_i(din2_q),
    .wr_ready_o(rx_wr_ready),
    .wr_level_o(rx_level),
    .rclk_i(clk_i),
    .rrst_n_i(rst_n_i),
    .rd_valid_o(host_rd_valid_o),
    .rd_data_o(host_rd_data_o),
    .rd_ready_i(host_rd_ready_i)
  );

  bpf_fifo #(.W(DW), .DEPTH(DEPTH)) u_tx_fifo (
    .wclk_i(clk_i),
    .wrst_n_i(rst_n_i),
    .wr_valid_i(host_wr_valid_i),
    .wr_data_i(host_wr_data_i),
    .wr_ready_o(host_wr_ready_o),
    .wr_level_o(),
    .rclk_i(link_clk_i),
    .rrst_n_i(lrst_n),
    .rd_valid_o(tx_rd_valid),
    .rd_data_o(tx_rd_data),
    .rd_ready_i(tx_pop)
  );

  // ****************************************
  // Receive path
  // ****************************************
  logic [ACKD-1:0] rx_dly_q;
  logic af_hit;
  // One word per strobe; strobe up to half the link rate
  assign rx_push = !tx_mode_s & strobe_rise & !rxgo_s_q[1]
                   & rx_wr_ready;
  assign af_hit = (LW+8)'(DEPTH) - (LW+8)'(rx_level) <= AF_FREE;

  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      rx_dly_q <= '0;
      rx_ack_o <= 1'b0;
      rx_almost_full_flag_o <= 1'b0;
    end else begin
      rx_dly_q <= {rx_dly_q[ACKD-2:0], rx_push};
      rx_ack_o <= rx_dly_q[ACKD-1];
      rx_almost_full_flag_o <= !tx_mode_s & af_hit;
    end
  end

  chk_rx_ack_delay: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) rx_push |-> ##(ACKD+1) rx_ack_o)
    else $error("receive ack missing after write");
  chk_rx_hold: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) rx_push |-> !rxgo_s_q[1] && rx_wr_ready)
    else $error("receive write while stopped or full");
  chk_af_flag: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) !tx_mode_s && af_hit |=>
      rx_almost_full_flag_o)
    else $error("almost full flag missed");

  // ****************************************
  // Transmit path
  // ****************************************
  logic [ACKD-1:0] tx_dly_q;
  assign tx_pop = tx_mode_s & strobe_rise & !txgo_s_q[1] & tx_rd_valid
                  & !tx_fifo_empty_flag_o;

  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      data_o <= '0;
      data_oe_o <= '0;
      tx_dly_q <= '0;
      tx_ack_o <= 1'b0;
      tx_fifo_empty_flag_o <= 1'b1;
    end else begin
      data_oe_o <= {DW{tx_mode_s}};
      if (tx_pop) begin
        data_o <= tx_rd_data;
      end
      tx_dly_q <= {tx_dly_q[ACKD-2:0], tx_pop};
      tx_ack_o <= tx_dly_q[ACKD-1];
      // Flag only moves with an ack or while no word is in flight
      if (tx_dly_q[ACKD-1] || (tx_dly_q == '0 && !tx_pop)) begin
        tx_fifo_empty_flag_o <= tx_mode_s & !tx_rd_valid;
      end
    end
  end

  chk_tx_pop_go: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) tx_pop |-> !txgo_s_q[1] && tx_mode_s)
    else $error("pop while transmit go is high");
  chk_tx_ack_delay: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) $rose(tx_ack_o) |-> $past(tx_pop, ACKD+1))
    else $error("transmit ack without earlier pop");
  chk_tx_hold: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) !tx_pop |=> $stable(data_o))
    else $error("bus word changed without pop");
  chk_empty_block: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) tx_fifo_empty_flag_o |-> !tx_pop)
    else $error("pop while empty flag high");
  chk_bus_group: assert property (@(posedge link_clk_i)
    disable iff (!lrst_n) data_oe_o != '0 |-> &data_oe_o)
    else $error("data lines split in direction");

  // ****************************************
  // Side ports
  // ****************************************
  logic [SIDE_W-1:0] side_s1_q;

  always_ff @(posedge clk_i) begin
    side_s1_q <= {side_port_a_i, side_port_b_i, side_port_c_i,
                  side_port_d_i};
    {side_a_in_o, side_b_in_o, side_c_in_o, side_d_in_o} <= side_s1_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      side_port_a_o <= '0;
      side_port_b_o <= '0;
      side_port_c_o <= '0;
      side_port_d_o <= '0;
      side_port_a_oe_o <= '0;
      side_port_b_oe_o <= '0;
      side_port_c_oe_o <= '0;
      side_port_d_oe_o <= '1;
    end else begin
      side_port_a_o <= side_a_out_i;
      side_port_b_o <= side_b_out_i;
      side_port_c_o <= side_c_out_i;
      side_port_d_o <= side_d_out_i;
      side_port_a_oe_o <= {bpf_pkg::PA_W{side_a_dir_i}};
      side_port_b_oe_o <= {bpf_pkg::PB_W{side_b_dir_i}};
      side_port_c_oe_o <= {bpf_pkg::PC_W{side_cd_dir_i}};
      side_port_d_oe_o <= {bpf_pkg::PD_W{~side_cd_dir_i}};
    end
  end

  chk_cd_opposite: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) side_port_c_oe_o[0] != side_port_d_oe_o[0])
    else $error("ports C and D share a direction");
endmodule : bpf_port

`default_nettype wire

// ===== verif/bpf_link_partner.sv
/*
 * Far-side model of the parallel link: word source in receive mode,
 * word sink in transmit mode, owner of both go lines.
 * Assumes the bench resolves the pulled-up bus from the port's enables.
 */
`timescale 1ns/1ns
`default_nettype none
module bpf_link_partner (
  input wire logic link_clk_i,
  input wire logic rx_ack_i,
  input wire logic tx_ack_i,
  input wire logic [bpf_pkg::DATA_W-1:0] bus_i,
  output logic [bpf_pkg::DATA_W-1:0] bus_o,
  output logic strobe_o,
  output logic rx_go_n_o,
  output logic tx_go_n_o
);
  logic [bpf_pkg::DATA_W-1:0] got_q[$];
  time ack_t[$];

  initial begin
    bus_o = 16'hffff;
    strobe_o = 1'b0;
    rx_go_n_o = 1'b1;
    tx_go_n_o = 1'b1;
  end

  // ****************************************
  // Capture on transmit acknowledge
  // ****************************************
  // Ack is a one-cycle pulse; look mid-cycle while it stands
  always @(negedge link_clk_i) begin
    if (tx_ack_i === 1'b1) begin
      got_q.push_back(bus_i);
      ack_t.push_back($time);
    end
  end

  task set_go(input logic rx, input logic tx);
    @(posedge link_clk_i);
    #2;
    rx_go_n_o = rx;
    tx_go_n_o = tx;
    // Go lines pass two sync flops
    repeat (4) @(posedge link_clk_i);
  endtask : set_go

  // ****************************************
  // One strobe, held until acknowledged or for at most ten cycles
  // ****************************************
  task word(input logic [15:0] w, input int gap, output logic acked);
    int n;
    @(posedge link_clk_i);
    #2;
    bus_o = w;
    strobe_o = 1'b1;
    acked = 1'b0;
    for (n = 0; n < 10 && !acked; n++) begin
      @(negedge link_clk_i);
      acked = (rx_ack_i === 1'b1) || (tx_ack_i === 1'b1);
    end
    @(posedge link_clk_i);
    #2;
    strobe_o = 1'b0;
    // Released bus floats to the pull-up level
    bus_o = 16'hffff;
    repeat (3 + gap) @(posedge link_clk_i);
  endtask : word
endmodule : bpf_link_partner
`default_nettype wire

// ===== verif/tb_bpf_port.sv
/*
 * Self-checking bench of the buffered parallel port: side ports,
 * receive fill and refusal, transmit drain, internal oscillator.
 * Assumes the partner model in bpf_link_partner.sv.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_bpf_port;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tx_mode_i = 1'b0;
  logic strobe_sel_i = 1'b0;
  logic [15:0] osc_div_i = 16'h0003;
  logic host_wr_valid_i = 1'b0;
  logic host_rd_ready_i = 1'b0;
  logic [15:0] host_wr_data_i = 16'h0000;
  logic side_a_dir_i = 1'b0;
  logic side_b_dir_i = 1'b0;
  logic side_cd_dir_i = 1'b0;
  logic [7:0] side_a_out_i = 8'hc3;
  logic [3:0] side_b_out_i = 4'h6;
  logic [2:0] side_c_out_i = 3'h2;
  logic [2:0] side_d_out_i = 3'h6;
  logic [15:0] data_i, data_o, data_oe_o, host_rd_data_o, part_bus;
  logic host_wr_ready_o, host_rd_valid_o, strobe_pin_i, rx_go_n_i;
  logic tx_go_n_i, rx_ack_o, tx_ack_o;
  logic rx_almost_full_flag_o, tx_fifo_empty_flag_o;
  logic [7:0] side_port_a_i, side_port_a_o, side_port_a_oe_o, side_a_in_o;
  logic [3:0] side_port_b_i, side_port_b_o, side_port_b_oe_o, side_b_in_o;
  logic [2:0] side_port_c_i, side_port_c_o, side_port_c_oe_o, side_c_in_o;
  logic [2:0] side_port_d_i, side_port_d_o, side_port_d_oe_o, side_d_in_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #50 clk_i = ~clk_i;
  // Rising edges of the two clocks never coincide
  always #16 link_clk_i = ~link_clk_i;

  // ****************************************
  // Wires seen at the pins
  // ****************************************
  assign data_i = (data_oe_o & data_o) | (~data_oe_o & part_bus);
  assign side_port_a_i = (side_port_a_oe_o & side_port_a_o) |
                         (~side_port_a_oe_o & 8'h5a);
  assign side_port_b_i = (side_port_b_oe_o & side_port_b_o) |
                         (~side_port_b_oe_o & 4'h9);
  assign side_port_c_i = (side_port_c_oe_o & side_port_c_o) |
                         (~side_port_c_oe_o & 3'h5);
  assign side_port_d_i = (side_port_d_oe_o & side_port_d_o) |
                         (~side_port_d_oe_o & 3'h1);

  bpf_port #(.DEPTH(16)) dut_u (
    .clk_i, .rst_n_i, .link_clk_i, .tx_mode_i, .strobe_sel_i, .osc_div_i,
    .host_wr_valid_i, .host_wr_data_i, .host_wr_ready_o, .host_rd_valid_o,
    .host_rd_data_o, .host_rd_ready_i, .data_i, .data_o, .data_oe_o,
    .strobe_pin_i, .rx_go_n_i, .tx_go_n_i, .rx_ack_o, .tx_ack_o,
    .rx_almost_full_flag_o, .tx_fifo_empty_flag_o, .side_a_dir_i,
    .side_b_dir_i, .side_cd_dir_i, .side_a_out_i, .side_b_out_i,
    .side_c_out_i, .side_d_out_i, .side_port_a_i, .side_port_b_i,
    .side_port_c_i, .side_port_d_i, .side_port_a_o, .side_port_b_o,
    .side_port_c_o, .side_port_d_o, .side_port_a_oe_o, .side_port_b_oe_o,
    .side_port_c_oe_o, .side_port_d_oe_o, .side_a_in_o, .side_b_in_o,
    .side_c_in_o, .side_d_in_o
  );

  bpf_link_partner peer_u (
    .link_clk_i, .rx_ack_i(rx_ack_o), .tx_ack_i(tx_ack_o), .bus_i(data_i),
    .bus_o(part_bus), .strobe_o(strobe_pin_i), .rx_go_n_o(rx_go_n_i),
    .tx_go_n_o(tx_go_n_i)
  );

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task conclude;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  // ****************************************
  // Host push and pop
  // ****************************************
  task hwrite(input logic [15:0] w);
    int n;
    @(posedge clk_i);
    #2;
    host_wr_valid_i = 1'b1;
    host_wr_data_i = w;
    n = 0;
    // Ready is settled mid-cycle; the push lands on the next rise
    do begin
      @(negedge clk_i);
      n++;
    end while (host_wr_ready_o !== 1'b1 && n < 50);
    @(posedge clk_i);
    #2;
    host_wr_valid_i = 1'b0;
  endtask : hwrite

  task hread(output logic [15:0] w);
    int n;
    @(posedge clk_i);
    #2;
    host_rd_ready_i = 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (host_rd_valid_o !== 1'b1 && n < 50);
    w = host_rd_data_o;
    @(posedge clk_i);
    #2;
    host_rd_ready_i = 1'b0;
  endtask : hread

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [15:0] w;
    logic ok;
    int i;
    repeat (16) @(posedge clk_i);
    check("d_oe_rst", 16'(side_port_d_oe_o), 16'h0007);
    #2;
    rst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    for (i = 0; i < 2; i++) begin
      #2;
      side_a_dir_i = i[0];
      side_b_dir_i = i[0];
      side_cd_dir_i = i[0];
      repeat (4) @(posedge clk_i);
      check("a_oe", 16'(side_port_a_oe_o), i ? 16'h00ff : 16'h0000);
      check("a_in", 16'(side_a_in_o), i ? 16'h00c3 : 16'h005a);
      check("b_in", 16'(side_b_in_o), i ? 16'h0006 : 16'h0009);
      check("c_oe", 16'(side_port_c_oe_o), i ? 16'h0007 : 16'h0000);
      check("d_oe", 16'(side_port_d_oe_o), i ? 16'h0000 : 16'h0007);
      check("c_in", 16'(side_c_in_o), i ? 16'h0002 : 16'h0005);
      check("d_in", 16'(side_d_in_o), i ? 16'h0001 : 16'h0006);
    end
    check("oe_rx", data_oe_o, 16'h0000);
    check("af_rx", 16'(rx_almost_full_flag_o), 16'h0001);
    peer_u.word(16'h1234, 0, ok);
    check("ack_go_hi", 16'(ok), 16'h0000);
    peer_u.set_go(1'b0, 1'b1);
    for (i = 0; i < 17; i++) begin
      peer_u.word(16'ha500 + 16'(i), i % 2, ok);
      check("rx_ack", 16'(ok), i < 16 ? 16'h0001 : 16'h0000);
    end
    for (i = 0; i < 16; i++) begin
      hread(w);
      check("rx_word", w, 16'ha500 + 16'(i));
    end
    repeat (4) @(posedge clk_i);
    check("rx_left", 16'(host_rd_valid_o), 16'h0000);
    peer_u.set_go(1'b1, 1'b1);
    #2;
    tx_mode_i = 1'b1;
    repeat (4) @(posedge clk_i);
    check("oe_tx", data_oe_o, 16'hffff);
    check("fe_idle", 16'(tx_fifo_empty_flag_o), 16'h0001);
    check("af_tx", 16'(rx_almost_full_flag_o), 16'h0000);
    for (i = 0; i < 16; i++) hwrite(16'h3c00 + 16'(i));
    repeat (4) @(posedge clk_i);
    check("wr_full", 16'(host_wr_ready_o), 16'h0000);
    check("fe_data", 16'(tx_fifo_empty_flag_o), 16'h0000);
    peer_u.word(16'h0000, 0, ok);
    check("ack_stall", 16'(ok), 16'h0000);
    check("hold_rst", data_o, 16'h0000);
    peer_u.set_go(1'b1, 1'b0);
    for (i = 0; i < 16; i++) begin
      peer_u.word(16'h0000, i % 3, ok);
      check("tx_ack", 16'(ok), 16'h0001);
      check("tx_word", peer_u.got_q[i], 16'h3c00 + 16'(i));
    end
    check("fe_drain", 16'(tx_fifo_empty_flag_o), 16'h0001);
    peer_u.word(16'h0000, 0, ok);
    check("ack_empty", 16'(ok), 16'h0000);
    check("hold_last", data_o, 16'h3c0f);
    peer_u.set_go(1'b1, 1'b1);
    #2;
    strobe_sel_i = 1'b1;
    osc_div_i = 16'h0005;
    for (i = 0; i < 4; i++) hwrite(16'h7700 + 16'(i));
    peer_u.set_go(1'b1, 1'b0);
    i = 0;
    while (peer_u.got_q.size() < 20 && i < 200) begin
      @(posedge clk_i);
      i++;
    end
    repeat (20) @(posedge clk_i);
    check("osc_cnt", 16'(peer_u.got_q.size()), 16'h0014);
    for (i = 0; i < 4; i++) begin
      check("osc_word", peer_u.got_q[16 + i], 16'h7700 + 16'(i));
    end
    // Divider 5 gives six link periods of 32 ns
    check("osc_gap", 16'(peer_u.ack_t[17] - peer_u.ack_t[16]), 16'h00c0);
    conclude();
  end
endmodule : tb_bpf_port
`default_nettype wire
